/* File: rx_frame.v */
// Receive frame engine of a multichannel serial port: registers, frame sequencing, sync error handling.
// Assumes the receive clock, frame sync and data come from a remote codec, slower than clk_sys by 4x or more.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "rx_frame_defines.vh"

// How it works
// - Channel selection enable at bit 0; clear means every channel of the frame, up to 256, is taken.
// - Selection set: only channels enabled in the enable registers; partition mode leaves the mapping unchanged.
// - Bit 6 of control 1 turns bit-level selection mode on.
// - In bit-level mode the enable registers A and B gate individual bits.
// - Bit 15 of receive control 2 picks single or dual phase frames.
// - Phase 1 word length at bits 7-5: 8,12,16,20,24,32; 11X reserved.
// - Single phase frames size every word by the phase 1 length.
// - Dual phase frames size phase 2 words by the phase 2 length field.
// - Phase 1 word count at bits 14-8, field plus one words.
// - Phase 2 word count at bits 14-8 of control 2, dual phase only.
// - Frame length is phase 1 count, plus phase 2 count when dual.
// - A frame sync before all words arrive is unexpected.
// - With sync ignore set, unexpected syncs are ignored and reception carries on.
// - Otherwise the word is aborted, shift contents dropped, error flag set, new word begun.
// - The lost word is not delivered; next word follows the data delay from new sync.
// - Receiver reset bit 0 of control 1 holds the receiver in reset when zero.
module rx_frame
(
	// Clock and reset.
	input wire clk_sys,
	input wire rst,
	// Register port.
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	output reg [15:0] rdata,
	// Receive link pins.
	input wire rx_clk,
	input wire rx_frame_sync,
	input wire rx_data,
	// Interrupt and word strobe.
	output reg irq,
	output reg word_valid
);

localparam ST_IDLE = 2'h0;
localparam ST_DELAY = 2'h1;
localparam ST_SHIFT = 2'h2;

reg [15:0] spc1_reg;
reg [15:0] multichannel_control_1_reg;
reg [15:0] receive_control_1_reg;
reg [15:0] receive_control_2_reg;
reg [15:0] rx_chan_enable_a;
reg [15:0] rx_chan_enable_b;
reg [15:0] tx_chan_enable_a;
reg [15:0] tx_chan_enable_b;
reg [`IRQ_WIDTH-1:0] irq_status_reg;
reg [`IRQ_WIDTH-1:0] irq_enable_reg;
reg [31:0] rx_shift_regs;
reg [31:0] data_reg;
reg [1:0] state_reg;
reg [5:0] bit_cnt_reg;
reg [7:0] word_cnt_reg;
reg [7:0] chan_reg;
reg phase2_reg;
reg [1:0] dly_cnt_reg;
reg [`IRQ_WIDTH-1:0] evt_reg;
wire [5:0] len_p1;
wire [5:0] len_p2;
wire [5:0] word_bits;
wire [7:0] frame_words;
wire [7:0] p1_words;
wire clk_level;
wire clk_fall;
wire fs_level;
wire fs_rise;
wire dat_level;
wire rx_enabled;
wire chan_on;
wire bit_on;
wire [5:0] bit_idx;

// Link pins pass two flip-flops before any logic reads them.
rx_pin_sync sync_clk (.clk_sys(clk_sys), .rst(rst), .pin(rx_clk), .level(clk_level), .rise(), .fall(clk_fall));
rx_pin_sync sync_fs (.clk_sys(clk_sys), .rst(rst), .pin(rx_frame_sync), .level(fs_level), .rise(fs_rise), .fall());
rx_pin_sync sync_dat (.clk_sys(clk_sys), .rst(rst), .pin(rx_data), .level(dat_level), .rise(), .fall());

// Word length decoders for both phases.
rx_word_len dec_p1 (.code(receive_control_1_reg[`WL_MSB:`WL_LSB]), .bits(len_p1));
rx_word_len dec_p2 (.code(receive_control_2_reg[`WL_MSB:`WL_LSB]), .bits(len_p2));

// Picks one enable bit for a channel or bit index from the two enable registers.
function enable_bit;
	input [7:0] idx;
	input [15:0] ena;
	input [15:0] enb;
	input part8;
	reg [4:0] slot;
	begin
		slot = idx[4:0];
		if (part8)
			enable_bit = slot[4] ? enb[slot[3:0]] : ena[slot[3:0]];
		else
			enable_bit = idx[4] ? enb[idx[3:0]] : ena[idx[3:0]];
	end
endfunction

assign rx_enabled = spc1_reg[`BIT_RX_RESET_N];
assign word_bits = phase2_reg ? len_p2 : len_p1;
assign p1_words = {1'b0, receive_control_1_reg[`WC_MSB:`WC_LSB]} + 8'h01;
// Last word index of the frame; a dual phase frame of 256 words would wrap a total, so the last index is compared.
assign frame_words = receive_control_2_reg[`BIT_PHASE_COUNT]
	? p1_words + {1'b0, receive_control_2_reg[`WC_MSB:`WC_LSB]}
	: p1_words - 8'h01;
// Channel filter: all channels without selection, else the enable registers.
assign chan_on = ~multichannel_control_1_reg[`BIT_CHANNEL_SELECT_EN]
	| enable_bit(chan_reg, rx_chan_enable_a, rx_chan_enable_b, multichannel_control_1_reg[`BIT_PARTITION_MODE]);
// Bit-level mode gates each received bit by its position in the word.
// The first bit of a word is taken on the boundary edge, while the counter still holds the old length.
assign bit_idx = (bit_cnt_reg == word_bits) ? 6'h00 : bit_cnt_reg;
assign bit_on = ~spc1_reg[`BIT_BIT_LEVEL_MODE]
	| enable_bit({2'h0, bit_idx}, rx_chan_enable_a, rx_chan_enable_b, 1'b0);

// Frame sequencer: delay, shift words, count words and phases, handle stray syncs.
always @(posedge clk_sys)
begin
	if (rst || !rx_enabled)
	begin
		evt_reg <= {`IRQ_WIDTH{1'b0}};
		state_reg <= ST_IDLE;
		bit_cnt_reg <= 6'h00;
		word_cnt_reg <= 8'h00;
		chan_reg <= 8'h00;
		phase2_reg <= 1'b0;
		dly_cnt_reg <= 2'h0;
		rx_shift_regs <= 32'h00000000;
		data_reg <= 32'h00000000;
		word_valid <= 1'b0;
	end
	else
	begin
		word_valid <= 1'b0;
		// Events are registered, so the status logic sees them one clean cycle later.
		evt_reg <= {`IRQ_WIDTH{1'b0}};
		if (fs_rise && (state_reg == ST_IDLE || !receive_control_2_reg[`BIT_SYNC_IGNORE]))
		begin
			// A sync mid-frame drops the partial word and restarts the frame.
			if (state_reg != ST_IDLE)
				evt_reg[`IRQ_SYNC_ERROR] <= 1'b1;
			rx_shift_regs <= 32'h00000000;
			bit_cnt_reg <= 6'h00;
			word_cnt_reg <= 8'h00;
			chan_reg <= 8'h00;
			phase2_reg <= 1'b0;
			dly_cnt_reg <= receive_control_2_reg[`DLY_MSB:`DLY_LSB];
			state_reg <= ST_DELAY;
		end
		else
		begin
			case (state_reg)
				ST_DELAY:
				begin
					if (clk_fall)
					begin
						if (dly_cnt_reg == 2'h0)
						begin
							rx_shift_regs <= {31'h0, dat_level & bit_on};
							bit_cnt_reg <= 6'h01;
							state_reg <= ST_SHIFT;
						end
						else
							dly_cnt_reg <= dly_cnt_reg - 2'h1;
					end
				end
				ST_SHIFT:
				begin
					if (clk_fall)
					begin
						if (bit_cnt_reg == word_bits)
						begin
							// Word boundary: deliver if the channel is on, then start next word on this same edge unless the frame is done.
							if (chan_on)
							begin
								data_reg <= rx_shift_regs;
								word_valid <= 1'b1;
								evt_reg[`IRQ_WORD_DONE] <= 1'b1;
							end
							chan_reg <= chan_reg + 8'h01;
							if (word_cnt_reg == frame_words)
							begin
								evt_reg[`IRQ_FRAME_DONE] <= 1'b1;
								state_reg <= ST_IDLE;
								bit_cnt_reg <= 6'h00;
							end
							else
							begin
								word_cnt_reg <= word_cnt_reg + 8'h01;
								if (word_cnt_reg + 8'h01 == p1_words && receive_control_2_reg[`BIT_PHASE_COUNT])
									phase2_reg <= 1'b1;
								rx_shift_regs <= {31'h0, dat_level & bit_on};
								bit_cnt_reg <= 6'h01;
							end
						end
						else
						begin
							rx_shift_regs <= {rx_shift_regs[30:0], dat_level & bit_on};
							bit_cnt_reg <= bit_cnt_reg + 6'h01;
						end
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
end

// Register writes; the sync error flag is set by hardware and the set wins over a clear.
always @(posedge clk_sys)
begin
	if (rst)
	begin
		spc1_reg <= `RST_16;
		multichannel_control_1_reg <= `RST_16;
		receive_control_1_reg <= `RST_16;
		receive_control_2_reg <= `RST_16;
		rx_chan_enable_a <= `RST_16;
		rx_chan_enable_b <= `RST_16;
		tx_chan_enable_a <= `RST_16;
		tx_chan_enable_b <= `RST_16;
		irq_enable_reg <= {`IRQ_WIDTH{1'b0}};
		irq_status_reg <= {`IRQ_WIDTH{1'b0}};
	end
	else
	begin
		if (wr && addr == `OFS_SERIAL_PORT_CONTROL_1)
			spc1_reg <= wdata;
		else if (wr && addr == `OFS_MULTICHANNEL_CONTROL_1)
			multichannel_control_1_reg <= wdata;
		else if (wr && addr == `OFS_RECEIVE_CONTROL_1)
			receive_control_1_reg <= wdata;
		else if (wr && addr == `OFS_RECEIVE_CONTROL_2)
			receive_control_2_reg <= wdata;
		else if (wr && addr == `OFS_RX_CHAN_ENABLE_A)
			rx_chan_enable_a <= wdata;
		else if (wr && addr == `OFS_RX_CHAN_ENABLE_B)
			rx_chan_enable_b <= wdata;
		else if (wr && addr == `OFS_TX_CHAN_ENABLE_A)
			tx_chan_enable_a <= wdata;
		else if (wr && addr == `OFS_TX_CHAN_ENABLE_B)
			tx_chan_enable_b <= wdata;
		else if (wr && addr == `OFS_IRQ_ENABLE)
			irq_enable_reg <= wdata[`IRQ_WIDTH-1:0];
		if (evt_reg[`IRQ_SYNC_ERROR])
			spc1_reg[`BIT_RX_SYNC_ERROR] <= 1'b1;
		if (wr && addr == `OFS_IRQ_CLEAR)
			irq_status_reg <= (irq_status_reg & ~wdata[`IRQ_WIDTH-1:0]) | evt_reg;
		else
			irq_status_reg <= irq_status_reg | evt_reg;
	end
end

// Read data, one cycle after the strobe; unmapped addresses read zero.
always @(posedge clk_sys)
begin
	if (rst)
		rdata <= 16'h0000;
	else if (!rd)
		rdata <= 16'h0000;
	else if (addr == `OFS_SERIAL_PORT_CONTROL_1)
		rdata <= spc1_reg;
	else if (addr == `OFS_MULTICHANNEL_CONTROL_1)
		rdata <= multichannel_control_1_reg;
	else if (addr == `OFS_RECEIVE_CONTROL_1)
		rdata <= receive_control_1_reg;
	else if (addr == `OFS_RECEIVE_CONTROL_2)
		rdata <= receive_control_2_reg;
	else if (addr == `OFS_RX_CHAN_ENABLE_A)
		rdata <= rx_chan_enable_a;
	else if (addr == `OFS_RX_CHAN_ENABLE_B)
		rdata <= rx_chan_enable_b;
	else if (addr == `OFS_TX_CHAN_ENABLE_A)
		rdata <= tx_chan_enable_a;
	else if (addr == `OFS_TX_CHAN_ENABLE_B)
		rdata <= tx_chan_enable_b;
	else if (addr == `OFS_IRQ_STATUS)
		rdata <= {13'h0000, irq_status_reg};
	else if (addr == `OFS_IRQ_ENABLE)
		rdata <= {13'h0000, irq_enable_reg};
	else if (addr == `OFS_RX_DATA_LO)
		rdata <= data_reg[15:0];
	else if (addr == `OFS_RX_DATA_HI)
		rdata <= data_reg[31:16];
	else if (addr == `OFS_RX_STATUS)
		rdata <= {state_reg, phase2_reg, fs_level, clk_level, 3'h0, word_cnt_reg};
	else
		rdata <= 16'h0000;
end

// Level interrupt from enabled sticky status bits.
always @(posedge clk_sys)
begin
	if (rst)
		irq <= 1'b0;
	else
		irq <= |(irq_status_reg & irq_enable_reg);
end

endmodule

/* File: rx_frame_defines.vh */
// Register offsets, field positions, reset values and word length encodings of the receive frame block.
// Included by the frame engine and the word length decoder; holds definitions only.
`ifndef RX_FRAME_DEFINES_VH
`define RX_FRAME_DEFINES_VH

// Register word offsets on the plain register port.
`define OFS_SERIAL_PORT_CONTROL_1 4'h0
`define OFS_MULTICHANNEL_CONTROL_1 4'h1
`define OFS_RECEIVE_CONTROL_1 4'h2
`define OFS_RECEIVE_CONTROL_2 4'h3
`define OFS_RX_CHAN_ENABLE_A 4'h4
`define OFS_RX_CHAN_ENABLE_B 4'h5
`define OFS_IRQ_STATUS 4'h6
`define OFS_IRQ_ENABLE 4'h7
`define OFS_IRQ_CLEAR 4'h8
`define OFS_RX_DATA_LO 4'h9
`define OFS_RX_DATA_HI 4'ha
`define OFS_RX_STATUS 4'hb
`define OFS_TX_CHAN_ENABLE_A 4'hc
`define OFS_TX_CHAN_ENABLE_B 4'hd

// Field positions in serial_port_control_1.
`define BIT_RX_RESET_N 0
`define BIT_RX_SYNC_ERROR 3
`define BIT_BIT_LEVEL_MODE 6
// Field positions in multichannel_control_1.
`define BIT_CHANNEL_SELECT_EN 0
`define BIT_PARTITION_MODE 9
// Field positions in the receive control registers.
`define BIT_PHASE_COUNT 15
`define BIT_SYNC_IGNORE 2
`define WL_MSB 7
`define WL_LSB 5
`define WC_MSB 14
`define WC_LSB 8
`define DLY_MSB 1
`define DLY_LSB 0

// Interrupt status bit positions.
`define IRQ_WORD_DONE 0
`define IRQ_SYNC_ERROR 1
`define IRQ_FRAME_DONE 2
`define IRQ_WIDTH 3

// Reset values.
`define RST_16 16'h0000

// Word length encodings.
`define WL_8 3'h0
`define WL_12 3'h1
`define WL_16 3'h2
`define WL_20 3'h3
`define WL_24 3'h4
`define WL_32 3'h5

`endif

/* File: rx_pin_sync.v */
// Two-stage synchroniser for receive link pins, with edge detection on the second stage output.
// Assumes asynchronous pins and one system clock; the first stage feeds only the second.
`timescale 1ns/10ps

module rx_pin_sync
(
	// Clock and reset.
	input wire clk_sys,
	input wire rst,
	// Pin in.
	input wire pin,
	// Synchronised level and edges.
	output reg level,
	output wire rise,
	output wire fall
);

reg stage1_reg;
reg level_d_reg;

// Two flip-flops, then a delayed copy for edge finding.
always @(posedge clk_sys)
begin
	if (rst)
	begin
		stage1_reg <= 1'b0;
		level <= 1'b0;
		level_d_reg <= 1'b0;
	end
	else
	begin
		stage1_reg <= pin;
		level <= stage1_reg;
		level_d_reg <= level;
	end
end

// Edges come only from the second stage and its delayed copy.
assign rise = level & ~level_d_reg;
assign fall = ~level & level_d_reg;

endmodule

/* File: rx_word_len.v */
// Decoder from a three-bit word length code to a bit count.
// Assumes callers keep reserved codes out; they decode to 32 bits here.
`timescale 1ns/10ps
`include "rx_frame_defines.vh"

module rx_word_len
(
	// Encoded length.
	input wire [2:0] code,
	// Length in bits.
	output reg [5:0] bits
);

// Maps each code to its number of bits.
always @*
begin
	case (code)
		`WL_8: bits = 6'h08;
		`WL_12: bits = 6'h0c;
		`WL_16: bits = 6'h10;
		`WL_20: bits = 6'h14;
		`WL_24: bits = 6'h18;
		default: bits = 6'h20;
	endcase
end

endmodule

/* File: rx_frame_properties.sv */
// Checker on the register port, interrupt and word strobe of the receive frame block.
// Assumes one clock domain with a synchronous reset; bound to rx_frame below.
`timescale 1ns/10ps

module rx_frame_properties
(
	// Clock and reset.
	input wire clk_sys,
	input wire rst,
	// Register port.
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	input wire [15:0] rdata,
	// Link pins and outputs.
	input wire rx_clk,
	input wire rx_frame_sync,
	input wire rx_data,
	input wire irq,
	input wire word_valid
);
	// All properties share the system clock and its reset.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_ctl_back;
		wr && addr == 4'h0 ##1 rd && addr == 4'h0 |=> (rdata & 16'h0041) == ($past(wdata, 2) & 16'h0041);
	endproperty
	a_ctl_back: assert property (p_ctl_back) else $error("control 1 readback");
	property p_mc_back;
		wr && addr == 4'h1 ##1 rd && addr == 4'h1 |=> (rdata & 16'h0201) == ($past(wdata, 2) & 16'h0201);
	endproperty
	a_mc_back: assert property (p_mc_back) else $error("multichannel readback");
	property p_rc1_back;
		wr && addr == 4'h2 ##1 rd && addr == 4'h2 |=> (rdata & 16'h7fe0) == ($past(wdata, 2) & 16'h7fe0);
	endproperty
	a_rc1_back: assert property (p_rc1_back) else $error("receive control 1 readback");
	property p_rc2_back;
		wr && addr == 4'h3 ##1 rd && addr == 4'h3 |=> rdata == $past(wdata, 2);
	endproperty
	a_rc2_back: assert property (p_rc2_back) else $error("receive control 2 readback");
	property p_held_quiet;
		wr && addr == 4'h0 && !wdata[0] |=> ##1 !word_valid [*8];
	endproperty
	a_held_quiet: assert property (p_held_quiet) else $error("word while receiver held");
	property p_valid_pulse;
		word_valid |=> !word_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("word strobe too long");
	property p_irq_masked;
		wr && addr == 4'h7 && wdata[2:0] == 3'h0 |=> ##1 !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq while all masked");
	property p_clear_wo;
		rd && (addr == 4'h8 || addr >= 4'he) |=> rdata == 16'h0000;
	endproperty
	a_clear_wo: assert property (p_clear_wo) else $error("unreadable word not zero");
endmodule

bind rx_frame rx_frame_properties chk_u (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .rx_clk(rx_clk), .rx_frame_sync(rx_frame_sync), .rx_data(rx_data), .irq(irq), .word_valid(word_valid));

/* File: rx_codec.sv */
// Behavioural codec on the receive link: bit clock, frame sync and MSB first data.
// Assumes a data delay of one bit; the clock stands still low between frames.
`timescale 1ns/10ps

module rx_codec
(
	// Link pins.
	output reg rx_clk = 1'b0,
	output reg rx_frame_sync = 1'b0,
	output reg rx_data = 1'b0
);
	// One 320 ns bit period: drive on the rise, the receiver samples on the fall.
	task bit_out(input s, input d);
	begin
		rx_clk = 1'b1;
		rx_frame_sync = s;
		rx_data = d;
		#160;
		rx_clk = 1'b0;
		#160;
	end
	endtask
	// Sends n1 words of l1 bits then n2 of l2; word k is base plus k.
	task send_frame(input [7:0] n1, input [5:0] l1, input [7:0] n2, input [5:0] l2, input [31:0] base,
		input [15:0] fs_bit);
		integer k;
		integer b;
		integer cnt;
		reg [31:0] w;
	begin
		cnt = 0;
		// Keeps every pin edge off the system clock edge, so the receiver never samples a changing pin.
		#5;
		bit_out(1'b1, ~rx_data);
		for (k = 0; k < n1 + n2; k = k + 1)
		begin
			w = base + k;
			for (b = ((k < n1) ? l1 : l2) - 1; b >= 0; b = b - 1)
			begin
				cnt = cnt + 1;
				bit_out(cnt == fs_bit, w[b]);
			end
		end
		bit_out(1'b0, ~rx_data);
	end
	endtask
endmodule

/* File: rx_frame_tb.sv */
// Self-checking bench of the receive frame block: register port tasks and link scenarios.
// Assumes the codec model drives the link pins and the checker is bound to the block.
`timescale 1ns/10ps

module rx_frame_tb;
	reg clk_sys = 1'b0;
	reg rst = 1'b1;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	wire [15:0] rdata;
	wire rx_clk;
	wire rx_frame_sync;
	wire rx_data;
	wire irq;
	wire word_valid;
	integer err_count = 0;
	integer check_count = 0;
	integer words = 0;
	integer k;
	reg [31:0] v;

	// System clock at 25 MHz and a count of delivered words.
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (word_valid === 1'b1)
			words <= words + 1;

	// Block under test and the codec on its link.
	rx_frame dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rx_clk(rx_clk), .rx_frame_sync(rx_frame_sync), .rx_data(rx_data), .irq(irq), .word_valid(word_valid));
	rx_codec codec_u (.rx_clk(rx_clk), .rx_frame_sync(rx_frame_sync), .rx_data(rx_data));

	// Compares a seen value with the expected one.
	task check(input [31:0] seen, input [31:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// One write cycle, then one read cycle judged in the cycle after its strobe.
	task reg_wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	end
	endtask
	task reg_chk(input [3:0] a, input [15:0] exp);
	begin
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	end
	endtask
	// A write and a read of the same word back to back, judged in the cycle after the read.
	task reg_wr_rd(input [3:0] a, input [15:0] d, input [15:0] exp);
	begin
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	end
	endtask
	// Programs the frame with the receiver held, clears status, releases it.
	task cfg(input [15:0] c1, input [15:0] c2, input [15:0] mc);
	begin
		reg_wr(4'h0, 16'h0000);
		reg_wr(4'h1, mc);
		reg_wr(4'h2, c1);
		reg_wr(4'h3, c2);
		reg_wr(4'h8, 16'h0007);
		reg_wr(4'h0, 16'h0001);
		words = 0;
	end
	endtask
	// Sends a frame of the given word counts and lengths and lets the last word settle.
	task frame(input [7:0] n1, input [5:0] l1, input [7:0] n2, input [5:0] l2, input [15:0] fs);
	begin
		codec_u.send_frame(n1, l1, n2, l2, 32'h9abcdef1, fs);
		repeat (12) @(posedge clk_sys);
	end
	endtask
	// Reset values and read-write storage; status ignores writes.
	task t_regs;
	begin
		for (k = 0; k < 16; k = k + 1)
			reg_chk(k[3:0], 16'h0000);
		reg_wr_rd(4'h0, 16'h0040, 16'h0040);
		reg_wr_rd(4'h1, 16'h0201, 16'h0201);
		reg_wr_rd(4'h2, 16'h7fe0, 16'h7fe0);
		reg_wr_rd(4'h3, 16'ha5c3, 16'ha5c3);
		reg_wr(4'h6, 16'hffff);
		reg_chk(4'h6, 16'h0000);
	end
	endtask
	// Every word length code but the reserved 11X ones, one right justified word per frame.
	task t_wlen;
	begin
		for (k = 0; k < 6; k = k + 1)
		begin
			cfg({8'h00, k[2:0], 5'h00}, 16'h0001, 16'h0000);
			v = (k == 5) ? 32 : 8 + 4 * k;
			frame(8'd1, v[5:0], 8'd0, 6'd8, 16'd0);
			check(words, 1);
			v = 32'h9abcdef1 & ~(32'hffffffff << v);
			reg_chk(4'h9, v[15:0]);
			reg_chk(4'ha, v[31:16]);
		end
	end
	endtask
	// Dual phase takes the phase two length and count; single phase ignores them.
	task t_dual;
	begin
		cfg(16'h0100, 16'h8041, 16'h0000);
		frame(8'd2, 6'd8, 8'd1, 6'd16, 16'd0);
		check(words, 3);
		reg_chk(4'h9, 16'hdef3);
		reg_chk(4'h6, 16'h0005);
		cfg(16'h0100, 16'h0041, 16'h0000);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd0);
		check(words, 2);
		reg_chk(4'h6, 16'h0005);
	end
	endtask
	// Selection on delivers only channel one; selection off delivers both; a held receiver takes nothing.
	// Bit-level mode keeps the first four bits of every word and clears the rest.
	task t_chan;
	begin
		reg_wr(4'h4, 16'h0002);
		cfg(16'h0100, 16'h0001, 16'h0001);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd0);
		check(words, 1);
		reg_chk(4'h9, 16'h00f2);
		cfg(16'h0100, 16'h0001, 16'h0000);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd0);
		check(words, 2);
		reg_wr(4'h0, 16'h0000);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd0);
		check(words, 2);
		reg_wr(4'h4, 16'h000f);
		cfg(16'h0100, 16'h0001, 16'h0000);
		reg_wr(4'h0, 16'h0041);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd0);
		check(words, 2);
		reg_chk(4'h9, 16'h00f0);
	end
	endtask
	// A sync inside word two is ignored when asked; otherwise the word is lost and flagged.
	task t_sync;
	begin
		cfg(16'h0100, 16'h0005, 16'h0000);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd12);
		check(words, 2);
		reg_chk(4'h9, 16'h00f2);
		reg_chk(4'h0, 16'h0001);
		cfg(16'h0100, 16'h0001, 16'h0000);
		reg_wr(4'h7, 16'h0002);
		frame(8'd2, 6'd8, 8'd0, 6'd8, 16'd12);
		check(words, 1);
		reg_chk(4'h9, 16'h00f1);
		reg_chk(4'h0, 16'h0009);
		check(irq, 1'b1);
		reg_wr(4'h7, 16'h0000);
		reg_chk(4'h6, 16'h0003);
		check(irq, 1'b0);
		reg_wr(4'h8, 16'h0002);
		reg_wr(4'h7, 16'h0002);
		reg_chk(4'h6, 16'h0001);
		check(irq, 1'b0);
	end
	endtask
	// Prints the verdict and ends the run.
	task stop_test;
	begin
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// Cuts a hung run short.
	initial
	begin
		#1000000;
		err_count = err_count + 1;
		stop_test;
	end
	// Reset for five cycles, then the scenarios.
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_regs;
		t_wlen;
		t_dual;
		t_chan;
		t_sync;
		stop_test;
	end
endmodule
